/* File: core/ssf_fault_flags.sv */
// serial slave holding the measurement and link fault flags of the angle sensor
`timescale 1ns/1ps
`default_nettype none
`include "ssf_regs.svh"

module ssf_fault_flags (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic        ss_n,
	output var  logic        miso,
	output logic             miso_oe,
	output var  logic        meas_start,
	output var  logic        meas_abort,
	input  wire logic        meas_done,
	input  wire logic        major_error,
	input  wire logic [11:0] angle_value,
	input  wire logic        strong_field_alarm,
	input  wire logic        weak_field_alarm,
	output logic [13:0]      fault_flags_register
);
	// ==================================================
	// helpers
	function automatic logic even_par(input logic [14:0] bits);
		even_par = ^bits;
	endfunction

	function automatic logic addr_known(input logic [13:0] a);
		addr_known = (a == `SSF_ADDR_NOP) || (a == `SSF_ADDR_POR_OFF) ||
			(a == `SSF_ADDR_SOFT_RST) || (a == `SSF_ADDR_FULL_RST) ||
			(a == `SSF_ADDR_CLR_ERR) || (a == `SSF_ADDR_AGC) ||
			(a == `SSF_ADDR_ANGLE) || (a == `SSF_ADDR_FAULT) ||
			(a == `SSF_ADDR_SYSCFG);
	endfunction

	// ==================================================
	// pin synchronisers
	logic sck_level;
	logic sck_rise;
	logic sck_fall;
	logic mosi_level;
	logic ss_level;
	logic ss_rise;
	logic ss_fall;

	ssf_pin_sync u_sck (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.pin         (sck),
		.reset_level (1'b0),
		.level       (sck_level),
		.rise        (sck_rise),
		.fall        (sck_fall)
	);

	ssf_pin_sync u_mosi (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.pin         (mosi),
		.reset_level (1'b0),
		.level       (mosi_level),
		.rise        (),
		.fall        ()
	);

	ssf_pin_sync u_ss (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.pin         (ss_n),
		.reset_level (1'b1),
		.level       (ss_level),
		.rise        (ss_rise),
		.fall        (ss_fall)
	);

	// ==================================================
	// frame shifting
	logic [15:0]            rx_shift;
	logic [15:0]            tx_shift;
	logic [4:0]             bit_count;
	logic                   in_frame;
	logic [15:0]            resp_word;
	ssf_pkg::ssf_frame_type frame_kind;

	// sample on falling sck, drive on rising sck; edges outside a frame are ignored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_shift  <= 16'h0000;
			bit_count <= 5'h00;
			in_frame  <= 1'b0;
		end else if (ss_fall) begin
			bit_count <= 5'h00;
			in_frame  <= 1'b1;
		end else if (ss_rise) begin
			in_frame  <= 1'b0;
		end else if (in_frame && sck_fall) begin
			rx_shift  <= {rx_shift[14:0], mosi_level};
			bit_count <= (bit_count == 5'h1f) ? bit_count : bit_count + 5'h01;
		end
	end

	// transmit shift loads the pending answer at frame start
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_shift <= 16'h0000;
			miso     <= 1'b0;
		end else if (ss_fall) begin
			tx_shift <= resp_word;
		end else if (in_frame && sck_rise) begin
			miso     <= tx_shift[15];
			tx_shift <= {tx_shift[14:0], 1'b0};
		end
	end

	// pin drives while selected, and also from reset until ss_level first goes high
	assign miso_oe = ~ss_level;

	// ==================================================
	// frame decode at frame end
	logic [13:0] rx_addr;
	logic        rx_read;
	logic        count_bad;
	logic        par_bad;
	logic        addr_bad;
	logic        is_cmd;
	logic        cmd_ok;
	logic        do_clear;
	logic        do_full_rst;
	logic        do_angle;
	logic        do_write;

	assign rx_addr     = rx_shift[`SSF_ADDR_MSB:`SSF_ADDR_LSB];
	assign rx_read     = rx_shift[`SSF_RW_BIT];
	assign is_cmd      = (frame_kind == ssf_pkg::SSF_FRAME_CMD);
	assign count_bad   = ss_rise && in_frame && (bit_count != `SSF_FRAME_BITS);
	assign par_bad     = ss_rise && in_frame && !count_bad &&
		(even_par(rx_shift[15:1]) != rx_shift[`SSF_PAR_BIT]);
	assign addr_bad    = ss_rise && in_frame && !count_bad && !par_bad && is_cmd &&
		!addr_known(rx_addr);
	assign cmd_ok      = ss_rise && in_frame && is_cmd && !count_bad && !par_bad && !addr_bad;
	assign do_clear    = cmd_ok && (rx_addr == `SSF_ADDR_CLR_ERR);
	assign do_full_rst = cmd_ok && (rx_addr == `SSF_ADDR_FULL_RST);
	assign do_angle    = cmd_ok && rx_read && (rx_addr == `SSF_ADDR_ANGLE);
	assign do_write    = cmd_ok && !rx_read;

	// a write command is followed by one data frame that is not decoded as a command
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_kind <= ssf_pkg::SSF_FRAME_CMD;
		end else if (ss_rise && in_frame) begin
			frame_kind <= do_write ? ssf_pkg::SSF_FRAME_WDATA : ssf_pkg::SSF_FRAME_CMD;
		end
	end

	// ==================================================
	// link fault flags; a new fault wins over a clear in the same cycle
	logic flag_par;
	logic flag_clk;
	logic flag_addr;
	logic next_flag_par;
	logic next_flag_clk;
	logic next_flag_addr;
	logic clr_links;

	assign clr_links      = do_clear | do_full_rst;
	assign next_flag_par  = par_bad | (flag_par & ~clr_links);
	assign next_flag_clk  = count_bad | (flag_clk & ~clr_links);
	assign next_flag_addr = addr_bad | (flag_addr & ~clr_links);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_par  <= 1'b0;
			flag_clk  <= 1'b0;
			flag_addr <= 1'b0;
		end else begin
			flag_par  <= next_flag_par;
			flag_clk  <= next_flag_clk;
			flag_addr <= next_flag_addr;
		end
	end

	// ==================================================
	// measurement tracking; a repeated angle read while busy is not restarted
	logic measurement_in_progress_flag;
	logic major_latched;
	logic next_meas;

	assign next_meas = do_full_rst ? 1'b0 :
		(do_angle && !measurement_in_progress_flag) ? 1'b1 :
		meas_done ? 1'b0 :
		measurement_in_progress_flag;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			measurement_in_progress_flag <= 1'b0;
			major_latched                <= 1'b0;
			meas_start                   <= 1'b0;
			meas_abort                   <= 1'b0;
		end else begin
			measurement_in_progress_flag <= next_meas;
			meas_start                   <= do_angle && !measurement_in_progress_flag;
			meas_abort                   <= do_full_rst;
			if (do_full_rst) begin
				major_latched <= 1'b0;
			end else if (measurement_in_progress_flag && meas_done) begin
				major_latched <= major_error;
			end
		end
	end

	// ==================================================
	// register views and answer word
	logic [13:0] angle_word;
	logic        alarm_force;
	logic        comm_error_indication;
	logic [13:0] resp_data;
	logic [15:0] next_resp;

	assign fault_flags_register = `SSF_FLT_RESET |
		({13'h0000, measurement_in_progress_flag} << `SSF_FLT_MEAS_BIT) |
		({13'h0000, flag_addr} << `SSF_FLT_ADDR_BIT) |
		({13'h0000, flag_clk} << `SSF_FLT_CLK_BIT) |
		({13'h0000, flag_par} << `SSF_FLT_PAR_BIT);

	assign alarm_force = major_latched | measurement_in_progress_flag;
	assign angle_word  = {weak_field_alarm | alarm_force,
		strong_field_alarm | alarm_force, angle_value};

	// unreadable or bad frames answer zero data
	assign resp_data = !rx_read ? 14'h0000 :
		(rx_addr == `SSF_ADDR_ANGLE) ? angle_word :
		((rx_addr == `SSF_ADDR_FAULT) || (rx_addr == `SSF_ADDR_CLR_ERR)) ?
		fault_flags_register : 14'h0000;

	// indication reflects faults of earlier frames plus this one
	assign comm_error_indication = next_flag_par | next_flag_clk | next_flag_addr |
		flag_par | flag_clk | flag_addr;
	assign next_resp = {(cmd_ok ? resp_data : 14'h0000), comm_error_indication,
		even_par({(cmd_ok ? resp_data : 14'h0000), comm_error_indication})};

	// answer is sent in the following frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			resp_word <= 16'h0000;
		end else if (ss_rise && in_frame) begin
			resp_word <= next_resp;
		end
	end
endmodule

`default_nettype wire

/* File: core/ssf_regs.svh */
// register addresses, field positions and frame constants for the serial fault flag block
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

// ==================================================
// frame layout
`define SSF_FRAME_BITS      5'h10
`define SSF_RW_BIT          15
`define SSF_ADDR_MSB        14
`define SSF_ADDR_LSB        1
`define SSF_PAR_BIT         0
`define SSF_EF_BIT          1

// ==================================================
// register and command addresses
`define SSF_ADDR_NOP        14'h0000
`define SSF_ADDR_POR_OFF    14'h3f22
`define SSF_ADDR_SOFT_RST   14'h3c00
`define SSF_ADDR_FULL_RST   14'h33a5
`define SSF_ADDR_CLR_ERR    14'h3380
`define SSF_ADDR_AGC        14'h3ff8
`define SSF_ADDR_ANGLE      14'h3fff
`define SSF_ADDR_FAULT      14'h335a
`define SSF_ADDR_SYSCFG     14'h3f20

// ==================================================
// fault_flags_register fields
`define SSF_FLT_MEAS_BIT    4
`define SSF_FLT_ADDR_BIT    2
`define SSF_FLT_CLK_BIT     1
`define SSF_FLT_PAR_BIT     0
`define SSF_FLT_RESET       14'h0000

// angle data fields
`define SSF_ANG_WEAK_BIT    13
`define SSF_ANG_STRONG_BIT  12

`endif

/* File: core/ssf_pkg.sv */
// types shared by the serial fault flag block
package ssf_pkg;
	// what the next frame is expected to carry
	typedef enum logic {
		SSF_FRAME_CMD,
		SSF_FRAME_WDATA
	} ssf_frame_type;
endpackage

/* File: core/ssf_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none

module ssf_pin_sync (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic pin,
	input  wire logic reset_level,
	output var  logic level,
	output logic      rise,
	output logic      fall
);
	logic ff1;
	logic ff2;
	logic ff3;
	logic prev;

	// ==================================================
	// sync chain; ff1 feeds only ff2 to keep metastability contained
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ff1 <= 1'b0;
			ff2 <= 1'b0;
			ff3 <= 1'b0;
		end else begin
			ff1 <= pin;
			ff2 <= ff1;
			ff3 <= ff2;
		end
	end

	// level moves only when two later stages agree
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b0;
			prev  <= 1'b0;
		end else begin
			level <= (ff2 == ff3) ? ff3 : level;
			prev  <= level;
		end
	end

	// reset_level is a constant tie; it hides a false edge right after reset
	logic started;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			started <= 1'b0;
		end else begin
			started <= started | (level == reset_level);
		end
	end

	assign rise = started & level & ~prev;
	assign fall = started & ~level & prev;
endmodule

`default_nettype wire

/* File: verification/ssf_fault_props.sv */
// assertion checker for the serial fault flag block
`timescale 1ns/1ps
`default_nettype none

module ssf_fault_props (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        ss_n,
	input wire logic        miso_oe,
	input wire logic        meas_start,
	input wire logic        meas_abort,
	input wire logic        meas_done,
	input wire logic [13:0] fault_flags_register
);
	// ==================================================
	// sequences
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_sel_held; !ss_n [*6]; endsequence
	sequence s_idle_held; ss_n [*6]; endsequence
	// ==================================================
	// properties
	property p_meas_set; meas_start |-> ##[0:2] fault_flags_register[4]; endproperty
	property p_meas_cause; $rose(fault_flags_register[4]) |-> ##[0:2] meas_start; endproperty
	property p_meas_clear;
		meas_done && fault_flags_register[4] && !meas_start |-> ##[1:3] !fault_flags_register[4];
	endproperty
	property p_abort_clear; meas_abort |-> ##[0:2] !fault_flags_register[4]; endproperty
	property p_addr_gap; $rose(fault_flags_register[2]) |-> ss_n; endproperty
	property p_clk_gap; $rose(fault_flags_register[1]) |-> ss_n; endproperty
	property p_par_gap; $rose(fault_flags_register[0]) |-> ss_n; endproperty
	property p_oe_on; $fell(ss_n) |-> ##[2:6] miso_oe; endproperty
	property p_oe_off; $rose(ss_n) ##1 s_idle_held |-> !miso_oe; endproperty
	// link flags only move once the frame has ended
	property p_link_hold; s_sel_held |-> $stable(fault_flags_register[2:0]); endproperty
	a_meas_set: assert property (p_meas_set)
		else $error("measure flag low after start");
	a_meas_cause: assert property (p_meas_cause)
		else $error("measure flag rose without start");
	a_meas_clear: assert property (p_meas_clear)
		else $error("measure flag stuck after done");
	a_abort_clear: assert property (p_abort_clear)
		else $error("measure flag stuck after abort");
	a_addr_gap: assert property (p_addr_gap)
		else $error("address flag set inside frame");
	a_clk_gap: assert property (p_clk_gap)
		else $error("clock flag set inside frame");
	a_par_gap: assert property (p_par_gap)
		else $error("parity flag set inside frame");
	a_oe_on: assert property (p_oe_on)
		else $error("no output enable in frame");
	a_oe_off: assert property (p_oe_off)
		else $error("output enable after frame");
	a_link_hold: assert property (p_link_hold)
		else $error("link flags moved inside frame");
endmodule

bind ssf_fault_flags ssf_fault_props ssf_fault_props_inst (.sys_clk, .rst_n, .ss_n, .miso_oe,
	.meas_start, .meas_abort, .meas_done, .fault_flags_register);

`default_nettype wire

/* File: verification/ssf_spi_host.sv */
// behavioural serial host that frames commands to the fault flag block
`timescale 1ns/1ps
`default_nettype none

module ssf_spi_host (
	input  wire logic miso_line,
	output var  logic sck,
	output var  logic mosi,
	output var  logic ss_n
);
	// ==================================================
	// link idle state
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		ss_n = 1'b1;
	end
	// one frame, msb first; sck runs only inside the frame
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = '0;
		ss_n = 1'b0;
		#800;
		for (int i = n - 1; i >= 0; i--) begin
			sck = 1'b1;
			mosi = tx[i[3:0]];
			#400;
			sck = 1'b0;
			#400;
			// sampled late in the low phase: the slave's output lags sck by its sync chain
			rx = {rx[14:0], miso_line};
		end
		ss_n = 1'b1;
		mosi = ~mosi; // released line must not look held
		#1200; // idle gap well over six system clocks
	endtask
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the serial fault flag block
`timescale 1ns/1ps
`default_nettype none
`include "ssf_regs.svh"

module tb_top;
	logic             sys_clk = 0, rst_n = 0, meas_done = 0, major_error = 0;
	logic             strong_field_alarm = 0, weak_field_alarm = 0, rx_ok = 0;
	logic [11:0]      angle_value = '0;
	logic [15:0]      rx_word, exp_q[$];
	wire logic        sck, mosi, ss_n, miso, miso_oe, meas_start, meas_abort;
	wire logic [13:0] fault_flags_register;
	wire logic        miso_line = miso_oe ? miso : 1'b1; // pull-up when released
	int               fails = 0, n_tests = 0;

	always #50 sys_clk = ~sys_clk;

	ssf_fault_flags ssf_fault_flags_inst (.sys_clk, .rst_n, .sck, .mosi, .ss_n, .miso, .miso_oe,
		.meas_start, .meas_abort, .meas_done, .major_error, .angle_value,
		.strong_field_alarm, .weak_field_alarm, .fault_flags_register);
	ssf_spi_host ssf_spi_host_inst (.miso_line, .sck, .mosi, .ss_n);

	// ==================================================
	// helpers
	function automatic logic [15:0] cmd(logic rd, logic [13:0] a);
		return {rd, a, ^{rd, a}};
	endfunction
	function automatic logic [15:0] rsp(logic [13:0] d, logic ef);
		return {d, ef, ^{d, ef}};
	endfunction
	task automatic chk(string what, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic flags(logic [13:0] e);
		repeat (2) @(negedge sys_clk);
		chk("flags", {2'b0, e}, {2'b0, fault_flags_register});
	endtask
	// reply of this frame is noted first, then handed to the watcher
	task automatic frame(logic [15:0] tx, int n, logic ck, logic [15:0] e);
		logic [15:0] r;
		if (ck) exp_q.push_back(e);
		ssf_spi_host_inst.xfer(tx, n, r);
		if (ck) begin
			@(negedge sys_clk);
			rx_word = r;
			rx_ok = 1'b1;
			@(negedge sys_clk);
			rx_ok = 1'b0;
		end
	endtask
	task automatic pulse_done(logic maj);
		@(negedge sys_clk);
		major_error = maj;
		meas_done = 1'b1;
		@(negedge sys_clk);
		meas_done = 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// watcher: oldest note against each reply seen
	always @(posedge sys_clk) if (rx_ok) chk("reply", exp_q.pop_front(), rx_word);

	// hang guard
	initial begin
		#3000000;
		fails++;
		$display("unexpected timeout exp done got hang");
		close_out();
	end

	// ==================================================
	// main sequence
	initial begin
		logic [13:0] a;
		void'($urandom(32'hc42fbb0a));
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (8) @(negedge sys_clk);
		flags(`SSF_FLT_RESET);
		frame(cmd(1, `SSF_ADDR_FAULT), 16, 0, 0);
		frame(cmd(1, `SSF_ADDR_NOP), 16, 1, rsp(0, 0));
		$display("test reset done");
		// parity fault, held across good frames until cleared
		frame(cmd(1, `SSF_ADDR_FAULT) ^ 16'h0001, 16, 0, 0);
		flags(14'h0001);
		frame(cmd(1, `SSF_ADDR_FAULT), 16, 1, rsp(0, 1));
		frame(cmd(1, `SSF_ADDR_NOP), 16, 1, rsp(14'h0001, 1));
		frame(cmd(0, `SSF_ADDR_CLR_ERR), 16, 0, 0);
		flags(14'h0000);
		$display("test parity done");
		// short and long frames
		for (int n = 15; n <= 17; n += 2) begin
			frame(cmd(1, `SSF_ADDR_NOP), n, 0, 0);
			flags(14'h0002);
			frame(cmd(1, `SSF_ADDR_CLR_ERR), 16, 0, 0);
			flags(14'h0000);
		end
		$display("test clock count done");
		// random unmapped address in 1000..1fff
		a = {2'b01, 12'($urandom)};
		frame(cmd(1, a), 16, 0, 0);
		flags(14'h0004);
		frame(cmd(1, `SSF_ADDR_NOP), 16, 1, rsp(0, 1));
		frame(cmd(1, `SSF_ADDR_CLR_ERR), 16, 0, 0);
		$display("test address done");
		// measurement: clean finish, major error, stuck then full reset
		@(negedge sys_clk);
		angle_value = 12'($urandom);
		{weak_field_alarm, strong_field_alarm} = 2'($urandom);
		frame(cmd(1, `SSF_ADDR_ANGLE), 16, 0, 0);
		flags(14'h0010);
		pulse_done(0);
		flags(14'h0000);
		frame(cmd(1, `SSF_ADDR_NOP), 16, 1,
			rsp({weak_field_alarm, strong_field_alarm, angle_value}, 0));
		frame(cmd(1, `SSF_ADDR_ANGLE), 16, 0, 0);
		pulse_done(1);
		// this reply answers the angle read taken before the error was latched
		frame(cmd(1, `SSF_ADDR_NOP), 16, 1,
			rsp({weak_field_alarm, strong_field_alarm, angle_value}, 0));
		major_error = 1'b0;
		frame(cmd(1, `SSF_ADDR_ANGLE), 16, 0, 0);
		frame(cmd(1, `SSF_ADDR_NOP), 16, 1, rsp({2'b11, angle_value}, 0));
		flags(14'h0010);
		frame(cmd(1, `SSF_ADDR_FULL_RST), 16, 0, 0);
		flags(14'h0000);
		$display("test measurement done");
		close_out();
	end
endmodule

`default_nettype wire
